// file: verilog/dma_legacy_command_interface.sv
// Legacy-mode DMA command block with bank registers, arbiter and data FIFO.
// Assumes host strobes, address and data synchronous to clk; dma_cs comes from system decode.
//
// Contract
// RQ1 - Status request bits follow request inputs even while masked.
// RQ2 - Terminal-count bits set on count end or end input; cleared by status read.
// RQ3 - Extended write makes write strobe match read strobe timing.
// RQ4 - Rotating-priority bit selects rotating arbitration instead of fixed.
// RQ5 - Disable bit blocks hold request despite valid requests; code lets a channel already in service keep hold until it ends.
// RQ6 - Request write sets or clears chosen channel's software request.
// RQ7 - Single-mask write masks or unmasks the chosen channel.
// RQ8 - All-mask write loads four mask bits; one masks, zero unmasks.
// RQ9 - Mode write applies bits 2 to 7 only to chosen channel.
// RQ10 - Transfer-mode field selects mode; one code means cascade.
// RQ11 - Address direction zero increments, one decrements per byte.
// RQ12 - Auto-initialize bit enables auto reload for the channel.
// RQ13 - Transfer-direction field selects channel transfer direction.
// RQ14 - Clear-pointer, initialize, clear-masks act on any write, data ignored.
// RQ15 - Clear-pointer write resets byte pointer; software issues it first.
// RQ16 - Initialize write returns the unit to its reset state; code keeps the bank registers and FIFO state.
// RQ17 - Clear-masks write unmasks all four channels.
// RQ18 - Bank bits 0 to 3 give A16 to A19; software writes upper zeros.
// RQ19 - Bank I/O address is relocation high byte plus low register at FFE1H.
// RQ20 - Grouping selects which address bits hold low address and bank index.
// RQ21 - Bank registers decode only in legacy mode when enabled; others always.
// RQ22 - Outside legacy mode, upper address comes from channel address high byte.
// RQ23 - Byte pointer clears at reset and command, toggles each address/count access.
// RQ24 - Command selection uses A3..A0 or A4..A1 by grouping bit.
// RQ25 - A15 carry enters A16 only when carry enable is set.
// RQ26 - Masked channels are never granted; unmasked software requests count.
// RQ27 - Write-only addresses read undefined; writes act at end of host cycle.
`timescale 1ns/1ps

module dma_byte_fifo
#(
  parameter int W = 8,
  parameter int D = 16
)
(
  input  wire logic         clk,
  input  wire logic         arst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(D);
  logic [W-1:0] mem [D];
  logic [AW:0]  wp_reg, wp_next, rp_reg, rp_next;
  logic         push, pop;

  assign in_ready  = (wp_reg - rp_reg) != (AW+1)'(D);
  assign out_valid = wp_reg != rp_reg;
  assign out_data  = mem[rp_reg[AW-1:0]];
  assign push      = in_valid & in_ready;
  assign pop       = out_valid & out_ready;

  always_comb
  begin
    wp_next = wp_reg + (AW+1)'(push);
    rp_next = rp_reg + (AW+1)'(pop);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_reg <= '0;
      rp_reg <= '0;
    end
    else
    begin
      wp_reg <= wp_next;
      rp_reg <= rp_next;
    end
  end

  // Storage has no reset; contents are only visible once written
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wp_reg[AW-1:0]] <= in_data;
  end
endmodule // dma_byte_fifo

module dma_legacy_command_interface
(
  input  wire logic                      clk,
  input  wire logic                      arst_n,
  input  wire logic [15:0]               io_addr,
  input  wire logic [dma_pkg::DW-1:0]    io_wdata,
  input  wire logic                      io_wr,
  input  wire logic                      io_rd,
  input  wire logic                      dma_cs,
  output logic [dma_pkg::DW-1:0]         io_rdata,
  input  wire logic                      address_grouping,
  input  wire logic                      legacy_mode,
  input  wire logic                      peripheral_select,
  input  wire logic                      carry_enable,
  input  wire logic [7:0]                high_page_relocation,
  input  wire logic [dma_pkg::NCH-1:0]   channel_request_in,
  input  wire logic [dma_pkg::NCH-1:0]   end_in,
  input  wire logic [dma_pkg::NCH-1:0]   count_end_in,
  input  wire logic                      addr_carry,
  input  wire logic [7:0]                chan_addr_high,
  input  wire logic                      hold_ack,
  output logic                           hold_request,
  output logic [dma_pkg::NCH-1:0]        grant,
  output logic                           xfer_rd_strobe,
  output logic                           xfer_wr_strobe,
  output logic [3:0]                     upper_address,
  output logic                           byte_pointer,
  output logic [2*dma_pkg::NCH-1:0]      transfer_mode_field,
  output logic [dma_pkg::NCH-1:0]        cascade_channel,
  output logic [dma_pkg::NCH-1:0]        address_direction,
  output logic [dma_pkg::NCH-1:0]        auto_reload_enable,
  output logic [2*dma_pkg::NCH-1:0]      transfer_direction,
  input  wire logic                      src_valid,
  output logic                           src_ready,
  input  wire logic [dma_pkg::DW-1:0]    src_data,
  output logic                           dst_valid,
  input  wire logic                      dst_ready,
  output logic [dma_pkg::DW-1:0]         dst_data
);
  import dma_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Decoding helpers

  function automatic logic [3:0] cmd_index(input logic [15:0] a, input logic g);
    cmd_index = g ? a[3:0] : a[4:1]; // RQ24
  endfunction

  function automatic logic [1:0] pick(input logic [NCH-1:0] r, input logic [1:0] base);
    logic [1:0] idx;
    pick = base;
    for (int i = NCH-1; i >= 0; i--)
    begin
      idx = base + 2'(i);
      if (r[idx])
        pick = idx;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Host cycle capture: writes act when the strobe falls

  logic [15:0]       addr_reg, addr_next;
  logic [7:0]        wdata_reg, wdata_next;
  logic              wr_q_reg, rd_q_reg;
  logic              wr_end, rd_end, cs_reg, cs_next;
  logic [3:0]        widx, ridx;
  logic              bank_hit;
  logic [1:0]        bank_idx;

  always_comb
  begin
    addr_next  = io_wr | io_rd ? io_addr : addr_reg;
    wdata_next = io_wr ? io_wdata : wdata_reg;
    cs_next    = io_wr | io_rd ? dma_cs : cs_reg;
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      addr_reg  <= '0;
      wdata_reg <= '0;
      cs_reg    <= 1'b0;
      wr_q_reg  <= 1'b0;
      rd_q_reg  <= 1'b0;
    end
    else
    begin
      addr_reg  <= addr_next;
      wdata_reg <= wdata_next;
      cs_reg    <= cs_next;
      wr_q_reg  <= io_wr;
      rd_q_reg  <= io_rd;
    end
  end

  assign wr_end = wr_q_reg & ~io_wr; // RQ27
  assign rd_end = rd_q_reg & ~io_rd;
  assign widx   = cmd_index(addr_reg, address_grouping);
  assign ridx   = cmd_index(io_addr, address_grouping);

  // Bank window follows the relocation byte and the low address register
  logic [7:0] bank_low_reg, bank_low_next, bank_sel_reg, bank_sel_next;

  always_comb
  begin
    bank_hit = legacy_mode & peripheral_select // RQ21
             & (addr_reg[15:8] == high_page_relocation); // RQ19
    if (address_grouping) // RQ20
    begin
      bank_hit = bank_hit & (addr_reg[7:2] == bank_low_reg[7:2]);
      bank_idx = addr_reg[1:0];
    end
    else
    begin
      bank_hit = bank_hit & (addr_reg[7:3] == bank_low_reg[7:3]) & (addr_reg[0] == bank_low_reg[0]);
      bank_idx = addr_reg[2:1];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  logic [7:0]     gcmd_reg, gcmd_next;
  logic [NCH-1:0] mask_reg, mask_next, sreq_reg, sreq_next, tc_reg, tc_next;
  logic [5:0]     mode_reg [NCH];
  logic [5:0]     mode_next [NCH];
  logic [7:0]     bank_reg [NCH];
  logic [7:0]     bank_next [NCH];
  logic           bp_reg, bp_next;
  logic           dma_wr, init_cmd, done;
  logic [1:0]     ch_reg, ch_next;
  logic [1:0]     sel;

  assign dma_wr   = wr_end & cs_reg;
  assign init_cmd = dma_wr & (widx == CMD_INIT); // RQ16 RQ14
  assign sel      = wdata_reg[1:0];

  always_comb
  begin
    gcmd_next     = gcmd_reg;
    mask_next     = mask_reg;
    sreq_next     = sreq_reg;
    bp_next       = bp_reg;
    bank_low_next = bank_low_reg;
    bank_sel_next = bank_sel_reg;
    mode_next     = mode_reg;
    bank_next     = bank_reg;
    tc_next       = tc_reg;
    if (rd_end & cs_reg & (widx == CMD_STATUS))
      tc_next = '0; // RQ2
    if (wr_end & (addr_reg == BANK_SEL_ADDR))
      bank_sel_next = wdata_reg;
    if (wr_end & (addr_reg == BANK_LOW_ADDR))
      bank_low_next = wdata_reg; // RQ19
    if (wr_end & bank_hit)
      bank_next[bank_idx] = wdata_reg; // RQ18
    if (cs_reg & ~widx[3] & (wr_end | rd_end))
      bp_next = ~bp_reg; // RQ23
    if (dma_wr)
    begin
      case (widx)
        CMD_STATUS:  gcmd_next = wdata_reg;
        CMD_REQUEST: sreq_next[sel] = wdata_reg[SET_BIT]; // RQ6
        CMD_SMASK:   mask_next[sel] = wdata_reg[SET_BIT]; // RQ7
        CMD_MODE:    mode_next[sel] = wdata_reg[7:2]; // RQ9
        CMD_CLRPTR:  bp_next = 1'b0; // RQ15 RQ14
        CMD_CLRMASK: mask_next = '0; // RQ17 RQ14
        CMD_ALLMASK: mask_next = wdata_reg[NCH-1:0]; // RQ8
        default:     ;
      endcase
    end
    // Count end ends the channel's soft request and, outside auto reload, also masks the channel
    if (done & (count_end_in[ch_reg] | end_in[ch_reg]))
    begin
      sreq_next[ch_reg] = 1'b0;
      if (!mode_reg[ch_reg][MD_AUTO-2]) // RQ12
        mask_next[ch_reg] = 1'b1;
    end
    tc_next = tc_next | count_end_in | end_in; // RQ2
    if (init_cmd)
    begin
      gcmd_next = GCMD_RST;
      mask_next = MASK_RST;
      sreq_next = '0;
      tc_next   = '0;
      bp_next   = 1'b0;
      mode_next = '{default: MODE_RST};
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gcmd_reg     <= GCMD_RST;
      mask_reg     <= MASK_RST;
      sreq_reg     <= '0;
      tc_reg       <= '0;
      bp_reg       <= 1'b0; // RQ23
      bank_low_reg <= BYTE_RST;
      bank_sel_reg <= BYTE_RST;
      mode_reg     <= '{default: MODE_RST};
      bank_reg     <= '{default: BYTE_RST};
    end
    else
    begin
      gcmd_reg     <= gcmd_next;
      mask_reg     <= mask_next;
      sreq_reg     <= sreq_next;
      tc_reg       <= tc_next;
      bp_reg       <= bp_next;
      bank_low_reg <= bank_low_next;
      bank_sel_reg <= bank_sel_next;
      mode_reg     <= mode_next;
      bank_reg     <= bank_next;
    end
  end

  assign byte_pointer = bp_reg;

  // Mode fields fan out per channel
  for (genvar c = 0; c < NCH; c++)
  begin : g_mode
    assign transfer_direction[2*c +: 2]  = mode_reg[c][MD_TRANSFER_DIRECTION-2 +: 2]; // RQ13
    assign auto_reload_enable[c]         = mode_reg[c][MD_AUTO-2]; // RQ12
    assign address_direction[c]          = mode_reg[c][MD_ADDRESS_DIRECTION-2]; // RQ11
    assign transfer_mode_field[2*c +: 2] = mode_reg[c][MD_TRANSFER_MODE_FIELD-2 +: 2]; // RQ10
    assign cascade_channel[c]            = mode_reg[c][MD_TRANSFER_MODE_FIELD-2 +: 2] == TRANSFER_MODE_FIELD_CASCADE; // RQ10
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data, registered while the read strobe is high

  logic [7:0] rdata_reg, rdata_next;

  always_comb
  begin
    rdata_next = rdata_reg;
    if (io_rd)
    begin
      rdata_next = '0; // RQ27
      if (io_addr == BANK_SEL_ADDR)
        rdata_next = bank_sel_reg;
      else if (io_addr == BANK_LOW_ADDR)
        rdata_next = bank_low_reg;
      else if (dma_cs & (ridx == CMD_STATUS))
      begin
        rdata_next[ST_RQ +: NCH] = channel_request_in; // RQ1
        rdata_next[ST_TC +: NCH] = tc_reg; // RQ2
      end
      else if (bank_hit)
        rdata_next = bank_reg[bank_idx];
    end
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= '0;
    else
      rdata_reg <= rdata_next;
  end

  assign io_rdata = rdata_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Arbiter and transfer strobes

  arb_state_e     state_reg, state_next;
  logic [1:0]     base_reg, base_next, ph_reg, ph_next;
  logic [NCH-1:0] live, gnt_reg, gnt_next;
  logic           rds_reg, rds_next, wrs_reg, wrs_next;
  logic [3:0]     up_reg, up_next;

  assign live = (channel_request_in | sreq_reg) & ~mask_reg; // RQ26
  assign done = state_reg == ST_SERVE;

  always_comb
  begin
    state_next = state_reg;
    base_next  = gcmd_reg[GC_ROTATE] ? base_reg : 2'h0; // RQ4
    ch_next    = ch_reg;
    gnt_next   = '0;
    ph_next    = 2'h0;
    case (state_reg)
      ST_IDLE:
        if (|live & ~gcmd_reg[GC_DISABLE]) // RQ5
          state_next = ST_HOLD;
      ST_HOLD:
        if (~|live | gcmd_reg[GC_DISABLE]) // RQ5
          state_next = ST_IDLE;
        else if (hold_ack)
        begin
          ch_next    = pick(live, base_next); // RQ4 RQ26
          state_next = ST_SERVE;
        end
      ST_SERVE:
      begin
        gnt_next[ch_reg] = 1'b1;
        ph_next          = ph_reg + 2'h1;
        if (~live[ch_reg] | count_end_in[ch_reg] | end_in[ch_reg] | ~hold_ack)
        begin
          state_next = ST_IDLE;
          gnt_next   = '0;
          if (gcmd_reg[GC_ROTATE])
            base_next = ch_reg + 2'h1; // RQ4
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
    // Initialize drops a running grant at once, as reset does
    if (init_cmd)
    begin
      state_next = ST_IDLE; // RQ16
      gnt_next   = '0;
    end
    rds_next = gnt_next[ch_next] & (ph_next != 2'h0);
    // Normal write is late by one phase; extended write matches read
    wrs_next = gnt_next[ch_next] & (gcmd_reg[GC_EXTWR] ? ph_next != 2'h0 : ph_next[1]); // RQ3
    if (legacy_mode)
      up_next = bank_reg[ch_next][3:0] + {3'h0, addr_carry & carry_enable}; // RQ18 RQ25
    else
      up_next = chan_addr_high[3:0]; // RQ22
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg <= ST_IDLE;
      base_reg  <= 2'h0;
      ch_reg    <= 2'h0;
      gnt_reg   <= '0;
      ph_reg    <= 2'h0;
      rds_reg   <= 1'b0;
      wrs_reg   <= 1'b0;
      up_reg    <= 4'h0;
    end
    else
    begin
      state_reg <= state_next;
      base_reg  <= base_next;
      ch_reg    <= ch_next;
      gnt_reg   <= gnt_next;
      ph_reg    <= ph_next;
      rds_reg   <= rds_next;
      wrs_reg   <= wrs_next;
      up_reg    <= up_next;
    end
  end

  assign hold_request   = state_reg != ST_IDLE; // RQ5
  assign grant          = gnt_reg;
  assign xfer_rd_strobe = rds_reg;
  assign xfer_wr_strobe = wrs_reg;
  assign upper_address  = up_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Transfer data buffer drains only while a channel is served

  logic fifo_valid;

  dma_byte_fifo #(.W(DW), .D(FIFO_DEPTH)) u_fifo
  (
    .clk       (clk),
    .arst_n    (arst_n),
    .in_valid  (src_valid),
    .in_ready  (src_ready),
    .in_data   (src_data),
    .out_valid (fifo_valid),
    .out_ready (dst_ready & done),
    .out_data  (dst_data)
  );

  assign dst_valid = fifo_valid & done;
endmodule // dma_legacy_command_interface

// file: verilog/dma_pkg.sv
// Constants, field layouts and types for the legacy DMA command interface.
// Assumes a byte-wide host I/O bus and four DMA channels.
package dma_pkg;
  localparam int          NCH            = 4;
  localparam int          DW             = 8;
  localparam int          FIFO_DEPTH     = 16;
  // Command index, taken from A3..A0 or A4..A1
  localparam logic [3:0]  CMD_STATUS     = 4'h8;
  localparam logic [3:0]  CMD_REQUEST    = 4'h9;
  localparam logic [3:0]  CMD_SMASK      = 4'hA;
  localparam logic [3:0]  CMD_MODE       = 4'hB;
  localparam logic [3:0]  CMD_CLRPTR     = 4'hC;
  localparam logic [3:0]  CMD_INIT       = 4'hD;
  localparam logic [3:0]  CMD_CLRMASK    = 4'hE;
  localparam logic [3:0]  CMD_ALLMASK    = 4'hF;
  localparam logic [15:0] BANK_SEL_ADDR  = 16'hFFE0;
  localparam logic [15:0] BANK_LOW_ADDR  = 16'hFFE1;
  // Global command bits
  localparam int          GC_DISABLE     = 2;
  localparam int          GC_ROTATE      = 4;
  localparam int          GC_EXTWR       = 5;
  // Request and single-mask data bit
  localparam int          SET_BIT        = 2;
  // Mode fields
  localparam int          MD_TRANSFER_DIRECTION        = 2;
  localparam int          MD_AUTO        = 4;
  localparam int          MD_ADDRESS_DIRECTION        = 5;
  localparam int          MD_TRANSFER_MODE_FIELD       = 6;
  localparam logic [1:0]  TRANSFER_MODE_FIELD_CASCADE  = 2'h3;
  // Status layout
  localparam int          ST_TC          = 0;
  localparam int          ST_RQ          = 4;
  // Reset values
  localparam logic [3:0]  MASK_RST       = 4'hF;
  localparam logic [7:0]  GCMD_RST       = 8'h00;
  localparam logic [5:0]  MODE_RST       = 6'h00;
  localparam logic [7:0]  BYTE_RST       = 8'h00;
  typedef enum logic [2:0]
  {
    ST_IDLE  = 3'b001,
    ST_HOLD  = 3'b010,
    ST_SERVE = 3'b100
  } arb_state_e;
endpackage

// file: verif/dma_cmd_sva.sv
// Checker of the legacy DMA command block; sees only its ports.
// Assumes host inputs change between rising edges of clk.
`timescale 1ns/1ps
module dma_cmd_sva
(
  input wire logic                      clk,
  input wire logic                      arst_n,
  input wire logic [15:0]               io_addr,
  input wire logic [dma_pkg::DW-1:0]    io_wdata,
  input wire logic                      io_wr,
  input wire logic                      io_rd,
  input wire logic                      dma_cs,
  input wire logic [dma_pkg::DW-1:0]    io_rdata,
  input wire logic                      address_grouping,
  input wire logic [dma_pkg::NCH-1:0]   channel_request_in,
  input wire logic                      hold_ack,
  input wire logic [dma_pkg::NCH-1:0]   grant,
  input wire logic                      xfer_rd_strobe,
  input wire logic                      xfer_wr_strobe,
  input wire logic                      byte_pointer,
  input wire logic [2*dma_pkg::NCH-1:0] transfer_mode_field,
  input wire logic [dma_pkg::NCH-1:0]   cascade_channel,
  input wire logic [dma_pkg::NCH-1:0]   address_direction
);
  import dma_pkg::*;
  logic [3:0] idx;
  logic [3:0] casc_exp;
  assign idx = address_grouping ? io_addr[3:0] : io_addr[4:1];
  always_comb
  begin
    for (int i = 0; i < NCH; i++)
      casc_exp[i] = (transfer_mode_field[2*i +: 2] == TRANSFER_MODE_FIELD_CASCADE);
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  //////////////////////////////////////////////////////////////////////////////
  a_grant_one_hot:
    assert property ($onehot0(grant)) else $error("grant not one-hot");
  a_grant_after_ack:
    assert property ($rose(|grant) |-> $past(hold_ack) && $past(hold_ack, 2))
    else $error("grant without hold acknowledge");
  a_wr_inside_rd:
    assert property (xfer_wr_strobe |-> xfer_rd_strobe) else $error("write strobe outside read strobe");
  a_status_live_req:
    assert property (io_rd && dma_cs && idx == CMD_STATUS |=> io_rdata[ST_RQ +: NCH] == $past(channel_request_in))
    else $error("status request bits wrong");
  a_ptr_clear_cmd:
    assert property ($fell(io_wr) && $past(dma_cs) && $past(idx) == CMD_CLRPTR |=> !byte_pointer)
    else $error("pointer not cleared");
  a_ptr_toggles:
    assert property ($fell(io_wr) && $past(dma_cs) && $past(idx) < 4'h8 |=> byte_pointer != $past(byte_pointer))
    else $error("pointer did not toggle");
  a_init_clears:
    assert property ($fell(io_wr) && $past(dma_cs) && $past(idx) == CMD_INIT |=>
      grant == 4'h0 && !byte_pointer && address_direction == 4'h0 && transfer_mode_field == 8'h00)
    else $error("initialize left state behind");
  a_mode_one_chan:
    assert property ($fell(io_wr) && $past(dma_cs) && $past(idx) == CMD_MODE |=>
      ((address_direction ^ $past(address_direction)) & ~(4'h1 << $past(io_wdata[1:0], 2))) == 4'h0 &&
      address_direction[$past(io_wdata[1:0], 2)] == $past(io_wdata[MD_ADDRESS_DIRECTION], 2))
    else $error("mode write reached the wrong channel");
  a_cascade_code:
    assert property (cascade_channel == casc_exp) else $error("cascade flags wrong");
endmodule // dma_cmd_sva

bind dma_legacy_command_interface dma_cmd_sva dma_cmd_sva_i (.*);

// file: verif/host_cpu_model.sv
// Host CPU model: byte I/O reads and writes, and the hold handshake.
// Assumes its tasks are called just after a falling edge of clk.
`timescale 1ns/1ps
module host_cpu_model
(
  input  wire logic       clk,
  input  wire logic       hold_request,
  input  wire logic [7:0] io_rdata,
  output logic [15:0]     io_addr,
  output logic [7:0]      io_wdata,
  output logic            io_wr,
  output logic            io_rd,
  output logic            dma_cs,
  output logic            hold_ack
);
  int ack_delay = 1;
  int ack_cnt   = 0;
  initial
  begin
    {io_addr, io_wdata, io_wr, io_rd, dma_cs, hold_ack} = '0;
  end
  //////////////////////////////////////////////////////////////////////////////
  // Released address and data lines show the inverse of the last value, so a stale latch shows up
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic cs);
    io_addr  = a;
    io_wdata = d;
    dma_cs   = cs;
    io_wr    = 1'b1;
    @(negedge clk);
    io_wr    = 1'b0;
    io_addr  = ~a;
    io_wdata = ~d;
    dma_cs   = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic rd(input logic [15:0] a, input logic cs, output logic [7:0] d);
    io_addr = a;
    dma_cs  = cs;
    io_rd   = 1'b1;
    repeat (2) @(negedge clk);
    d       = io_rdata;
    io_rd   = 1'b0;
    io_addr = ~a;
    dma_cs  = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic bank_wr(input logic [15:0] a, input logic [7:0] d);
    wr(a, {4'h0, d[3:0]}, 1'b0);
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Acknowledge after ack_delay cycles; drop at once when the request goes
  always @(negedge clk)
  begin
    if (!hold_request)
    begin
      ack_cnt  = 0;
      hold_ack = 1'b0;
    end
    else if (ack_cnt < ack_delay)
      ack_cnt++;
    else
      hold_ack = 1'b1;
  end
endmodule // host_cpu_model

// file: verif/testbench.sv
// Self-checking bench of the legacy DMA command block with its host model.
// Assumes dma_pkg and the design are compiled first; one 25 MHz clock.
`timescale 1ns/1ps
module testbench;
  import dma_pkg::*;
  logic        clk = 1'b0, arst_n = 1'b0;
  logic [15:0] io_addr;
  logic [7:0]  io_wdata, io_rdata, high_page_relocation, chan_addr_high, src_data, dst_data;
  logic [7:0]  transfer_mode_field, transfer_direction, r, d, exp_tm, exp_td;
  logic        io_wr, io_rd, dma_cs, hold_ack, hold_request, address_grouping, legacy_mode;
  logic        peripheral_select, carry_enable, addr_carry, xfer_rd_strobe, xfer_wr_strobe;
  logic        byte_pointer, src_valid, src_ready, dst_valid, dst_ready;
  logic [3:0]  channel_request_in, end_in, count_end_in, grant, upper_address, req;
  logic [3:0]  cascade_channel, address_direction, auto_reload_enable, exp_ad, exp_au;
  logic [7:0]  fq[$];
  int          err_total = 0, tests_run = 0, cyc = 0, gap = 0, n;
  dma_legacy_command_interface dma_legacy_command_interface_i (.*);
  host_cpu_model host_cpu_model_i (.*);
  always #20 clk = ~clk;
  //////////////////////////////////////////////////////////////////////////////
  function automatic logic [7:0] lfsr(input logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  function automatic logic [15:0] ca(input logic [3:0] i);
    return address_grouping ? {12'h000, i} : {11'h000, i, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic cmd(input logic [3:0] i, input logic [7:0] v);
    host_cpu_model_i.wr(ca(i), v, 1'b1);
  endtask
  task automatic wait_grant(input logic [3:0] e);
    for (int k = 0; k < 40 && grant !== e; k++)
      @(negedge clk);
    chk("grant", {4'h0, grant}, {4'h0, e});
  endtask
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  // Stream monitor takes the oldest noted byte; also counts read-only strobe cycles
  always @(posedge clk)
  begin
    cyc++;
    if (|grant && xfer_rd_strobe && !xfer_wr_strobe)
      gap++;
    if (dst_valid && dst_ready)
      chk("dst_data", dst_data, (fq.size() > 0) ? fq.pop_front() : ~dst_data);
    if (cyc == 6000)
    begin
      err_total++;
      results();
    end
  end
  initial
  begin
    {address_grouping, legacy_mode, peripheral_select, carry_enable, addr_carry} = 5'b11101;
    {high_page_relocation, chan_addr_high, src_data, r} = {8'h12, 8'h3C, 8'h00, 8'h19};
    {channel_request_in, end_in, count_end_in, src_valid, dst_ready} = 14'h0000;
    {exp_tm, exp_td, exp_ad, exp_au} = 24'h000000;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    @(negedge clk);
    chk("reset", {hold_request, grant, byte_pointer, src_ready, dst_valid}, 8'h02);
    r = lfsr(r);
    req = r[3:0];
    channel_request_in = req;
    count_end_in = 4'h2;
    @(negedge clk);
    count_end_in = 4'h0;
    end_in = 4'h4;
    @(negedge clk);
    end_in = 4'h0;
    host_cpu_model_i.rd(ca(CMD_STATUS), 1'b1, d);
    chk("status", d, {req, 4'h6});
    host_cpu_model_i.rd(ca(CMD_STATUS), 1'b1, d);
    chk("status_again", d, {req, 4'h0});
    host_cpu_model_i.rd(ca(CMD_REQUEST), 1'b1, d);
    chk("write_only", d, 8'h00);
    channel_request_in = 4'h0;
    for (int ch = 0; ch < 4; ch++)
    begin
      r = lfsr(r);
      d = {(ch == 3) ? 2'b11 : {1'b0, r[6]}, r[5:2], ch[1:0]};
      address_grouping = ch[0];
      cmd(CMD_MODE, d);
      exp_tm[2*ch +: 2] = d[7:6];
      exp_td[2*ch +: 2] = d[3:2];
      {exp_ad[ch], exp_au[ch]} = d[5:4];
      chk("mode_tm", transfer_mode_field, exp_tm);
      chk("mode_td", transfer_direction, exp_td);
      chk("mode_bits", {address_direction, auto_reload_enable}, {exp_ad, exp_au});
      chk("cascade", {4'h0, cascade_channel}, (ch == 3) ? 8'h08 : 8'h00);
    end
    cmd(CMD_INIT, r);
    chk("init", {address_direction, auto_reload_enable} | transfer_mode_field, 8'h00);
    cmd(CMD_CLRPTR, ~r);
    for (int i = 0; i < 3; i++)
    begin
      r = lfsr(r);
      cmd(i[3:0], r);
      chk("ptr", {7'h00, byte_pointer}, {7'h00, ~i[0]});
    end
    cmd(CMD_CLRPTR, r);
    chk("ptr_clear", {7'h00, byte_pointer}, 8'h00);
    cmd(CMD_STATUS, 8'h01 << GC_DISABLE);
    cmd(CMD_REQUEST, 8'h06);
    cmd(CMD_CLRMASK, lfsr(r));
    repeat (4) @(negedge clk);
    chk("disabled", {7'h00, hold_request}, 8'h00);
    cmd(CMD_STATUS, 8'h00);
    wait_grant(4'h4);
    cmd(CMD_SMASK, 8'h06);
    wait_grant(4'h0);
    host_cpu_model_i.ack_delay = 6;
    cmd(CMD_ALLMASK, 8'h0B);
    wait_grant(4'h4);
    gap = 0;
    repeat (8) @(negedge clk);
    chk("plain_wr", {7'h00, gap != 0}, 8'h01);
    cmd(CMD_ALLMASK, 8'h0F);
    wait_grant(4'h0);
    cmd(CMD_REQUEST, 8'h02);
    cmd(CMD_SMASK, 8'h02);
    repeat (6) @(negedge clk);
    chk("no_request", {7'h00, hold_request}, 8'h00);
    host_cpu_model_i.wr(BANK_LOW_ADDR, 8'h40, 1'b0);
    address_grouping = 1'b0;
    host_cpu_model_i.bank_wr({high_page_relocation, 8'h44}, 8'h05);
    address_grouping = 1'b1;
    peripheral_select = 1'b0;
    host_cpu_model_i.bank_wr({high_page_relocation, 8'h42}, 8'h0A);
    peripheral_select = 1'b1;
    host_cpu_model_i.rd({high_page_relocation, 8'h42}, 1'b0, d);
    chk("bank", d, 8'h05);
    for (n = 0; src_ready === 1'b1 && n < 40; n++)
    begin
      r = lfsr(r);
      src_valid = 1'b1;
      src_data = r;
      fq.push_back(r);
      @(negedge clk);
    end
    src_valid = 1'b0;
    chk("fill", n[7:0], 8'(FIFO_DEPTH));
    chk("idle_hold", {7'h00, dst_valid}, 8'h00);
    cmd(CMD_STATUS, 8'h01 << GC_EXTWR);
    cmd(CMD_REQUEST, 8'h06);
    cmd(CMD_SMASK, 8'h02);
    wait_grant(4'h4);
    gap = 0;
    chk("upper", {4'h0, upper_address}, 8'h05);
    for (int k = 0; k < 400 && fq.size() > 0; k++)
    begin
      r = lfsr(r);
      dst_ready = r[0];
      @(negedge clk);
    end
    dst_ready = 1'b0;
    chk("drained", {fq.size() == 0, dst_valid}, 8'h02);
    chk("ext_wr", gap[7:0], 8'h00);
    results();
  end
endmodule // testbench
